/* dv/tcr_pin_model.sv */
`timescale 1ns/1ps
// Far-side pin driver: idle-high pins, one low pulse per command
module tcr_pin_model (
  // Clock and commands
  input wire logic clk,
  input wire logic cnt_go,
  input wire logic trig_go,
  // Pins
  output logic count_input_pin,
  output logic trigger_pin
);
  initial begin
    count_input_pin = 1'b1;
    trigger_pin = 1'b1;
  end
  always @(posedge clk) begin
    if (cnt_go) begin
      count_input_pin <= 1'b0;
      repeat (4) @(posedge clk);
      count_input_pin <= 1'b1;
    end
  end
  always @(posedge clk) begin
    if (trig_go) begin
      trigger_pin <= 1'b0;
      repeat (4) @(posedge clk);
      trigger_pin <= 1'b1;
    end
  end
endmodule : tcr_pin_model

/* dv/timer2_capture_reload_tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench: register bus, pins, interrupt and UART clocks
module timer2_capture_reload_tb_top
  import tcr_pkg::*;
;
  logic clk, rst_n, read, write, cnt_go, trig_go, trigger_pin, count_input_pin;
  logic uart_rx_clock, uart_tx_clock, irq, waitrequest;
  logic [7:0] address, q, rh;
  logic [3:0] be;
  logic [7:0] exp_q [$];
  logic [31:0] writedata, readdata, seed, v;
  int n_fail, n_tests, nrx, ntx, n;
  logic [7:0] regs [4] = '{ADDR_RC_LOW, ADDR_RC_HIGH, ADDR_COUNT_LOW, ADDR_COUNT_HIGH};
  tcr_timer2 u_tcr_timer2 (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
    .trigger_pin(trigger_pin), .count_input_pin(count_input_pin), .uart_rx_clock(uart_rx_clock),
    .uart_tx_clock(uart_tx_clock), .irq(irq));
  tcr_pin_model u_tcr_pin_model (.clk(clk), .cnt_go(cnt_go), .trig_go(trig_go),
    .count_input_pin(count_input_pin), .trigger_pin(trigger_pin));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // UART clock pulse counters
  always @(posedge clk) begin
    if (uart_rx_clock === 1'b1) nrx++;
    if (uart_tx_clock === 1'b1) ntx++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk);
    address <= a;
    writedata <= {24'h000000, d};
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    r = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask : rd
  // One falling edge on the chosen pin
  task automatic pulse(input logic trig);
    @(posedge clk);
    if (trig) trig_go <= 1'b1;
    else cnt_go <= 1'b1;
    @(posedge clk);
    trig_go <= 1'b0;
    cnt_go <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : pulse
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  // Main sequence
  initial begin
    seed = 32'h6d3acd07;
    {rst_n, read, write, cnt_go, trig_go, nrx, ntx} = '0;
    address = 8'h00;
    writedata = 32'h00000000;
    be = 4'hF;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_CONTROL, RST_BYTE);
    foreach (regs[i]) rd(regs[i], RST_BYTE);
    rd(8'h40, 8'h00);
    // Write without byte lane 0 is ignored
    be <= 4'h0;
    wr(ADDR_RC_LOW, 8'hA5);
    be <= 4'hF;
    rd(ADDR_RC_LOW, RST_BYTE);
    // Shadow queue of written bytes, read back after all writes
    foreach (regs[i]) begin
      v = $random(seed);
      wr(regs[i], v[7:0]);
      exp_q.push_back(v[7:0]);
    end
    foreach (regs[i]) rd(regs[i], exp_q.pop_front());
    // Counter mode counts pin edges, stops when run is off
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h06);
    n = 3 + ($random(seed) & 7);
    repeat (n) pulse(1'b0);
    rd(ADDR_COUNT_LOW, 8'(n));
    wr(ADDR_CONTROL, 8'h02);
    pulse(1'b0);
    rd(ADDR_COUNT_LOW, 8'(n));
    // Capture on trigger edge
    wr(ADDR_CONTROL, 8'h0F);
    pulse(1'b1);
    rd(ADDR_RC_LOW, 8'(n));
    rd(ADDR_RC_HIGH, 8'h00);
    rd(ADDR_CONTROL, 8'h4F);
    // Reload on trigger edge
    v = $random(seed);
    wr(ADDR_RC_LOW, v[7:0]);
    wr(ADDR_RC_HIGH, v[15:8]);
    wr(ADDR_CONTROL, 8'h0E);
    pulse(1'b1);
    rd(ADDR_COUNT_LOW, v[7:0]);
    rd(ADDR_COUNT_HIGH, v[15:8]);
    rd(ADDR_CONTROL, 8'h4E);
    wr(ADDR_CONTROL, 8'h06);
    pulse(1'b1);
    rd(ADDR_CONTROL, 8'h06);
    // Timer overflow with auto-reload
    rh = 8'($random(seed));
    wr(ADDR_COUNT_LOW, 8'hFE);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_RC_LOW, 8'h00);
    wr(ADDR_RC_HIGH, rh);
    wr(ADDR_CONTROL, 8'h04);
    repeat (20) @(posedge clk);
    rd(ADDR_CONTROL, 8'h84);
    rd(ADDR_COUNT_HIGH, rh);
    // Count rate over a fixed run
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h84);
    repeat (100) @(posedge clk);
    wr(ADDR_CONTROL, 8'h80);
    bus(1'b0, ADDR_COUNT_LOW, 8'h00, q);
    chk(8'(q >= 8'd48 && q <= 8'd54), 8'h01);
    // Interrupt status, mask and clear
    rd(ADDR_IRQ_STATUS, 8'h03);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h02);
    // UART clocks from overflow, trigger and capture select ignored
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, 8'hFE);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    nrx = 0;
    ntx = 0;
    wr(ADDR_CONTROL, 8'h3D);
    pulse(1'b1);
    rd(ADDR_CONTROL, 8'h3D);
    rd(ADDR_COUNT_HIGH, rh);
    chk(8'(nrx), 8'h01);
    chk(8'(ntx), 8'h01);
    rd(ADDR_RC_LOW, 8'h00);
    // Receive select alone drives only the receive clock
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, 8'hFE);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    nrx = 0;
    ntx = 0;
    wr(ADDR_CONTROL, 8'h24);
    repeat (10) @(posedge clk);
    chk(8'(nrx), 8'h01);
    chk(8'(ntx), 8'h00);
    rd(ADDR_CONTROL, 8'h24);
    finish_test();
  end
endmodule : timer2_capture_reload_tb_top

/* rtl/tcr_pkg.sv */
package tcr_pkg;
  // Register byte addresses (printed offsets are word aligned)
  localparam logic [7:0] ADDR_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_RC_LOW = 8'hCA;
  localparam logic [7:0] ADDR_RC_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hD0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hD4;
  // Control bit positions
  localparam int BIT_OVF = 7;
  localparam int BIT_EXT = 6;
  localparam int BIT_RXSEL = 5;
  localparam int BIT_TXSEL = 4;
  localparam int BIT_TRIGEN = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_CNTSEL = 1;
  localparam int BIT_CAPSEL = 0;
  // Interrupt status bit positions
  localparam int IRQ_OVF = 0;
  localparam int IRQ_EXT = 1;
  localparam int IRQ_W = 2;
  // Reset value and top count
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // Timer tick every two system clocks
  localparam int TICK_DIV = 2;
  localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
  typedef enum logic [1:0] {
    TCR_IDLE,
    TCR_DONE
  } tcr_bus_t;
  typedef struct packed {
    logic [7:0] control;
    logic [15:0] rc;
    logic [15:0] count;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic tick;
    logic [1:0] trig_sync;
    logic trig_prev;
    logic [1:0] cnt_sync;
    logic cnt_prev;
    tcr_bus_t bus;
    logic waitrequest;
    logic [31:0] readdata;
    logic irq;
    logic rx_clk;
    logic tx_clk;
  } tcr_state_t;
endpackage : tcr_pkg

/* rtl/tcr_timer2.sv */
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
// Function
// R1 - Overflow sets overflow flag unless a UART clock select is set; software clears.
// R2 - Trigger edge causing capture or reload sets external trigger flag; software clears.
// R3 - Receive clock select picks this timer's overflow for UART receive clock.
// R4 - Transmit clock select picks this timer's overflow for UART transmit clock.
// R5 - Trigger edge acts only with trigger enable set and both clock selects clear.
// R6 - Run control zero stops the counter, one lets it count.
// R7 - Timer mode increments the count once every two system clocks.
// R8 - Counter mode increments on each falling edge of the count input pin.
// R9 - Reload mode reloads on overflow and on enabled trigger falling edges.
// R10 - Capture mode captures count on enabled trigger falling edges.
// R11 - Any UART clock select forces auto-reload on overflow.
// R12 - Reload/capture value is two read/write bytes resetting to zero.
// R13 - Count is two read/write bytes resetting to zero.
// R14 - Reload copies reload value into count; capture copies count into it.
// R15 - Pin falling edges found by synchronous sampling against previous sample.
module tcr_timer2
  import tcr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Pins
  input wire logic trigger_pin,
  input wire logic count_input_pin,
  // UART clocks and interrupt
  output logic uart_rx_clock,
  output logic uart_tx_clock,
  output logic irq
);
  logic [1:0] rst_sync;
  logic srst_n;
  tcr_state_t cur;
  tcr_state_t nxt;
  logic trig_fall;
  logic cnt_fall;
  logic uart_sel;
  logic inc;
  logic ovf;
  logic reload;
  logic capture;
  logic ext_event;
  logic wr;
  logic rd;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign srst_n = rst_sync[1];

  // Outputs straight from flip-flops
  assign readdata = cur.readdata;
  assign waitrequest = cur.waitrequest;
  assign irq = cur.irq;
  assign uart_rx_clock = cur.rx_clk;
  assign uart_tx_clock = cur.tx_clk;

  // Event decode
  always_comb begin
    // R15 synchronous edge detect
    trig_fall = cur.trig_prev & ~cur.trig_sync[1];
    cnt_fall = cur.cnt_prev & ~cur.cnt_sync[1];
    uart_sel = cur.control[BIT_RXSEL] | cur.control[BIT_TXSEL];
    // R6 R7 R8 run gating and tick source
    inc = cur.control[BIT_RUN] & (cur.control[BIT_CNTSEL] ? cnt_fall : cur.tick);
    ovf = inc & (cur.count == COUNT_MAX);
    // R5 trigger qualification
    ext_event = trig_fall & cur.control[BIT_TRIGEN] & ~uart_sel;
    // R9 R11 reload sources
    reload = ovf & (uart_sel | ~cur.control[BIT_CAPSEL])
           | ext_event & ~cur.control[BIT_CAPSEL];
    // R10 capture on trigger
    capture = ext_event & cur.control[BIT_CAPSEL];
    wr = write & cur.waitrequest & (cur.bus == TCR_IDLE);
    rd = read & cur.waitrequest & (cur.bus == TCR_IDLE);
  end

  // Next state
  always_comb begin
    nxt = cur;
    // Two-stage pin synchronisers
    nxt.trig_sync = {cur.trig_sync[0], trigger_pin};
    nxt.trig_prev = cur.trig_sync[1];
    nxt.cnt_sync = {cur.cnt_sync[0], count_input_pin};
    nxt.cnt_prev = cur.cnt_sync[1];
    // R7 divide-by-two tick
    nxt.tick = (TICK_DIV == 2) ? ~cur.tick : 1'b0;
    // Software register writes, hardware events applied after
    if (wr) begin
      if (address == ADDR_CONTROL && byteenable[0]) begin
        nxt.control = writedata[7:0];
      end else if (address == ADDR_RC_LOW && byteenable[0]) begin
        nxt.rc[7:0] = writedata[7:0];
      end else if (address == ADDR_RC_HIGH && byteenable[0]) begin
        nxt.rc[15:8] = writedata[7:0];
      end else if (address == ADDR_COUNT_LOW && byteenable[0]) begin
        nxt.count[7:0] = writedata[7:0];
      end else if (address == ADDR_COUNT_HIGH && byteenable[0]) begin
        nxt.count[15:8] = writedata[7:0];
      end else if (address == ADDR_IRQ_STATUS && byteenable[0]) begin
        nxt.irq_status = cur.irq_status & ~writedata[IRQ_W-1:0];
      end else if (address == ADDR_IRQ_MASK && byteenable[0]) begin
        nxt.irq_mask = writedata[IRQ_W-1:0];
      end
    end
    // Counting on top of any software byte write, so a write while running is lost only to a reload or capture in the same cycle
    if (inc) begin
      nxt.count = nxt.count + 16'h0001;
    end
    // R14 reload and capture transfers
    if (reload) begin
      nxt.count = cur.rc;
    end
    if (capture) begin
      nxt.rc = cur.count;
    end
    // R1 overflow flag, set wins over clear
    if (ovf & ~uart_sel) begin
      nxt.control[BIT_OVF] = 1'b1;
      nxt.irq_status[IRQ_OVF] = 1'b1;
    end
    // R2 trigger flag, set wins over clear
    if (ext_event) begin
      nxt.control[BIT_EXT] = 1'b1;
      nxt.irq_status[IRQ_EXT] = 1'b1;
    end
    // R3 R4 UART clock pulses from this timer's overflow
    nxt.rx_clk = ovf & cur.control[BIT_RXSEL];
    nxt.tx_clk = ovf & cur.control[BIT_TXSEL];
    nxt.irq = |(nxt.irq_status & nxt.irq_mask);
    // Bus handshake: one wait cycle then acknowledge
    nxt.waitrequest = 1'b1;
    nxt.bus = TCR_IDLE;
    if (rd | wr) begin
      nxt.waitrequest = 1'b0;
      nxt.bus = TCR_DONE;
      nxt.readdata = READ_UNMAPPED;
      if (rd) begin
        // R12 R13 readable bytes
        if (address == ADDR_CONTROL) begin
          nxt.readdata[7:0] = cur.control;
        end else if (address == ADDR_RC_LOW) begin
          nxt.readdata[7:0] = cur.rc[7:0];
        end else if (address == ADDR_RC_HIGH) begin
          nxt.readdata[7:0] = cur.rc[15:8];
        end else if (address == ADDR_COUNT_LOW) begin
          nxt.readdata[7:0] = cur.count[7:0];
        end else if (address == ADDR_COUNT_HIGH) begin
          nxt.readdata[7:0] = cur.count[15:8];
        end else if (address == ADDR_IRQ_STATUS) begin
          nxt.readdata[IRQ_W-1:0] = cur.irq_status;
        end else if (address == ADDR_IRQ_MASK) begin
          nxt.readdata[IRQ_W-1:0] = cur.irq_mask;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.waitrequest <= 1'b1;
      cur.bus <= TCR_IDLE;
    end else if (!srst_n) begin
      cur <= '0;
      cur.waitrequest <= 1'b1;
      cur.bus <= TCR_IDLE;
    end else begin
      cur <= nxt;
    end
  end

  // Assertions
  // R1 overflow flag set
  property p_ovf_flag;
    @(posedge clk) disable iff (!srst_n) (ovf && !uart_sel) |=> cur.control[BIT_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set"); // R1
  // R1 no flag with uart select
  property p_ovf_quiet;
    @(posedge clk) disable iff (!srst_n)
      (uart_sel && !cur.control[BIT_OVF] && !wr) |=> !cur.control[BIT_OVF];
  endproperty
  a_ovf_quiet: assert property (p_ovf_quiet) else $error("overflow flag set in uart mode"); // R1
  // R2 trigger flag
  property p_ext_flag;
    @(posedge clk) disable iff (!srst_n) ext_event |=> cur.control[BIT_EXT];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("trigger flag not set"); // R2
  // R3 receive clock
  property p_rx_clk;
    @(posedge clk) disable iff (!srst_n) (ovf && cur.control[BIT_RXSEL]) |=> uart_rx_clock;
  endproperty
  a_rx_clk: assert property (p_rx_clk) else $error("rx clock missing"); // R3
  // R4 transmit clock
  property p_tx_clk;
    @(posedge clk) disable iff (!srst_n) uart_tx_clock |-> $past(cur.control[BIT_TXSEL]);
  endproperty
  a_tx_clk: assert property (p_tx_clk) else $error("tx clock without select"); // R4
  // R6 stopped counter holds
  property p_stop;
    @(posedge clk) disable iff (!srst_n)
      (!cur.control[BIT_RUN] && !wr && !ext_event) |=> (cur.count == $past(cur.count));
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped"); // R6
  // R7 timer increments every two cycles
  property p_timer_rate;
    @(posedge clk) disable iff (!srst_n)
      (inc && !cur.control[BIT_CNTSEL] && !reload && !capture) ##1 (!wr && cur.control[BIT_RUN] && !cur.control[BIT_CNTSEL])
        |-> !inc;
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer ticked twice"); // R7
  // R9 overflow reload
  property p_reload;
    @(posedge clk) disable iff (!srst_n) (ovf && !cur.control[BIT_CAPSEL]) |=> cur.count == $past(cur.rc);
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed"); // R9
  // R10 capture copies count
  property p_capture;
    @(posedge clk) disable iff (!srst_n) capture |=> cur.rc == $past(cur.count);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed"); // R10
  // R5 trigger ignored when disabled
  property p_trig_off;
    @(posedge clk) disable iff (!srst_n)
      (!cur.control[BIT_TRIGEN] && !wr) |=> (cur.control[BIT_EXT] == $past(cur.control[BIT_EXT]));
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger acted while disabled"); // R5
  // R8 pin edge increments
  property p_count_pin;
    @(posedge clk) disable iff (!srst_n)
      (cur.control[BIT_RUN] && cur.control[BIT_CNTSEL] && cnt_fall && !reload && !wr)
        |=> cur.count == $past(cur.count) + 16'h0001;
  endproperty
  a_count_pin: assert property (p_count_pin) else $error("count pin edge not counted"); // R8
  // R7 timer tick increments
  property p_timer_step;
    @(posedge clk) disable iff (!srst_n)
      (cur.control[BIT_RUN] && !cur.control[BIT_CNTSEL] && cur.tick && !reload && !wr)
        |=> cur.count == $past(cur.count) + 16'h0001;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer tick not counted"); // R7
  // R11 forced overflow reload
  property p_force_reload;
    @(posedge clk) disable iff (!srst_n) (ovf && uart_sel) |=> cur.count == $past(cur.rc);
  endproperty
  a_force_reload: assert property (p_force_reload) else $error("uart mode reload missed"); // R11
  // R9 trigger reload
  property p_trig_reload;
    @(posedge clk) disable iff (!srst_n)
      (ext_event && !cur.control[BIT_CAPSEL]) |=> cur.count == $past(cur.rc);
  endproperty
  a_trig_reload: assert property (p_trig_reload) else $error("trigger reload missed"); // R9
  // R12 reload low byte write
  property p_rc_low_write;
    @(posedge clk) disable iff (!srst_n)
      (wr && address == ADDR_RC_LOW && byteenable[0] && !capture) |=> cur.rc[7:0] == $past(writedata[7:0]);
  endproperty
  a_rc_low_write: assert property (p_rc_low_write) else $error("reload low byte write lost"); // R12
  // R12 reload high byte write
  property p_rc_high_write;
    @(posedge clk) disable iff (!srst_n)
      (wr && address == ADDR_RC_HIGH && byteenable[0] && !capture) |=> cur.rc[15:8] == $past(writedata[7:0]);
  endproperty
  a_rc_high_write: assert property (p_rc_high_write) else $error("reload high byte write lost"); // R12
  // R13 count low byte write
  property p_count_low_write;
    @(posedge clk) disable iff (!srst_n)
      (wr && address == ADDR_COUNT_LOW && byteenable[0] && !inc && !reload)
        |=> cur.count[7:0] == $past(writedata[7:0]);
  endproperty
  a_count_low_write: assert property (p_count_low_write) else $error("count low byte write lost"); // R13
  // R13 count high byte write
  property p_count_high_write;
    @(posedge clk) disable iff (!srst_n)
      (wr && address == ADDR_COUNT_HIGH && byteenable[0] && !inc && !reload)
        |=> cur.count[15:8] == $past(writedata[7:0]);
  endproperty
  a_count_high_write: assert property (p_count_high_write) else $error("count high byte write lost"); // R13
  // R15 synchronised pin edge
  property p_pin_edge;
    @(posedge clk) disable iff (!srst_n)
      ($fell(cur.cnt_sync[1]) && cur.control[BIT_RUN] && cur.control[BIT_CNTSEL]) |-> inc;
  endproperty
  a_pin_edge: assert property (p_pin_edge) else $error("count pin edge missed"); // R15
  // R5 trigger ignored in uart mode
  property p_ext_quiet;
    @(posedge clk) disable iff (!srst_n)
      (uart_sel && !cur.control[BIT_EXT] && !wr) |=> !cur.control[BIT_EXT];
  endproperty
  a_ext_quiet: assert property (p_ext_quiet) else $error("trigger acted in uart mode"); // R5
  // R1 R2 interrupt level
  property p_irq_level;
    @(posedge clk) disable iff (!srst_n) irq == |(cur.irq_status & cur.irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong"); // R1
  // R12 R13 single acknowledge cycle
  property p_wait_one;
    @(posedge clk) disable iff (!srst_n) !waitrequest |=> waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long"); // R12
  // R3 receive clock source
  property p_rx_only;
    @(posedge clk) disable iff (!srst_n)
      uart_rx_clock |-> ($past(ovf) && $past(cur.control[BIT_RXSEL]));
  endproperty
  a_rx_only: assert property (p_rx_only) else $error("rx clock without overflow"); // R3
  // R4 transmit clock pulse
  property p_tx_pulse;
    @(posedge clk) disable iff (!srst_n) (ovf && cur.control[BIT_TXSEL]) |=> uart_tx_clock;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx clock missing"); // R4
  // R1 overflow flag sticky
  property p_ovf_stay;
    @(posedge clk) disable iff (!srst_n) (cur.control[BIT_OVF] && !wr) |=> cur.control[BIT_OVF];
  endproperty
  a_ovf_stay: assert property (p_ovf_stay) else $error("overflow flag cleared by hardware"); // R1
  // R2 trigger flag sticky
  property p_ext_stay;
    @(posedge clk) disable iff (!srst_n) (cur.control[BIT_EXT] && !wr) |=> cur.control[BIT_EXT];
  endproperty
  a_ext_stay: assert property (p_ext_stay) else $error("trigger flag cleared by hardware"); // R2
  // R1 overflow status bit
  property p_status_ovf;
    @(posedge clk) disable iff (!srst_n) (ovf && !uart_sel) |=> cur.irq_status[IRQ_OVF];
  endproperty
  a_status_ovf: assert property (p_status_ovf) else $error("overflow status not set"); // R1
  // R2 trigger status bit
  property p_status_ext;
    @(posedge clk) disable iff (!srst_n) ext_event |=> cur.irq_status[IRQ_EXT];
  endproperty
  a_status_ext: assert property (p_status_ext) else $error("trigger status not set"); // R2
  // Covers
  c_ovf: cover property (@(posedge clk) disable iff (!srst_n) ovf);
  c_capture: cover property (@(posedge clk) disable iff (!srst_n) capture);
  c_irq: cover property (@(posedge clk) disable iff (!srst_n) irq);
  c_uart: cover property (@(posedge clk) disable iff (!srst_n) uart_rx_clock);
  c_trig_reload: cover property (@(posedge clk) disable iff (!srst_n) ext_event && !cur.control[BIT_CAPSEL]);
endmodule : tcr_timer2
